// ### hdl/pct_regs.svh
// Register map, reset values, field positions and pattern codes
// Assumes a 32-bit Wishbone slave; each register index is a word
// What this block does
// - Compliance bit 4 enables 10BASE-T patterns
// - Extended bit 4 enables 100BASE-TX test mode
// - Codes 0-5: pulses, repeats, preamble
// - Codes 6-9: pulse+idle, 1001, random
// - 100BASE-TX code is {ext bit5, select[3:0]}
// - Send one then code-count zeros
// - Code zero sends only zeros
// - Converged when error below 15-bit limit
// - 3-bit field sets gain retrain interval
// - Bit selects gain recalibration step size
// - Bits pick energy-lost trigger and clear
`ifndef PCT_REGS_SVH
`define PCT_REGS_SVH
// Register indexes; byte address is four times the index
`define PCT_IDX_COMPT   12'h027
`define PCT_IDX_DSP     12'h101
`define PCT_IDX_ENWIN   12'h10A
`define PCT_IDX_MSE     12'h123
`define PCT_IDX_GAIN    12'h130
`define PCT_IDX_EXT     12'h428
// Reset values
`define PCT_RST_COMPT   16'h0000
`define PCT_RST_DSP     16'h2082
`define PCT_RST_ENWIN   16'h2040
`define PCT_RST_MSE     16'h051C
`define PCT_RST_GAIN    16'h4F28
`define PCT_RST_EXT     16'h0000
// Writable bit masks
`define PCT_WM_COMPT    16'h001F
`define PCT_WM_DSP      16'hFF9F
`define PCT_WM_ENWIN    16'hFFFF
`define PCT_WM_MSE      16'h7FFF
`define PCT_WM_GAIN     16'h7FFF
`define PCT_WM_EXT      16'h0030
// Field positions
`define PCT_EN_BIT      4
`define PCT_CODE_MSB    5
`define PCT_MSE_HI      14
`define PCT_RT_HI       14
`define PCT_RT_LO       12
`define PCT_GAIN_EN     11
`define PCT_STEP_BIT    10
`define PCT_ELT_BIT     9
`define PCT_ELC_BIT     8
`define PCT_WD_HI       7
`define PCT_WD_OFF      4
// Misc constants
`define PCT_LFSR_SEED   16'hACE1
`define PCT_LFSR_TAPS   16'hB400
`endif

// ### hdl/pct_pkg.sv
// Types shared by the compliance test and DSP tuning block
// Assumes pct_regs.svh supplies the numeric constants
package pct_pkg;
    // Test engine mode, Gray coded along idle -> 10M -> 100M
    typedef enum logic [1:0] {
        PCT_IDLE = 2'h0,
        PCT_T10  = 2'h1,
        PCT_T100 = 2'h3
    } pct_mode_e;
    // One line symbol towards the transmit pair
    typedef struct packed {
        logic data;   // Symbol value
        logic drive;  // Pair driven
        logic idle;   // Idle waveform phase
    } pct_line_s;
    // DSP tuning fields handed to the receive datapath
    typedef struct packed {
        logic [7:0] energyLostTh;   // Energy lost threshold
        logic       dfeFreeze;      // Equaliser freeze
        logic       watchdogOff;    // Sequencer watchdog off
        logic [2:0] badMseTime;     // Bad error timer select
        logic       edgeOnlyInt;    // Energy edge only
        logic [7:0] energyWindow;   // Energy window length
        logic [7:0] energyOnTh;     // Energy on threshold
        logic       gainStep;       // Recalibration step
        logic       energyLostTrig; // Energy lost trigger
        logic       energyLostClr;  // Energy lost clear mode
        logic [7:0] sequencerWatchdogCount; // Watchdog count
    } pct_dsp_s;
endpackage

// ### hdl/pct_compliance_dsp.sv
// Compliance test pattern engine and DSP tuning registers
// Assumes a classic Wishbone master and a 50 MHz sys_clk
`timescale 1ns/10ps
`include "pct_regs.svh"
module pct_compliance_dsp #(
    parameter int TICK_DIV     = 5,     // Clocks per line symbol
    parameter int FRAME_LEN    = 16,    // Symbols per repeat
    parameter int RETRAIN_BASE = 8192   // Clocks at interval 0
) (
    input  wire logic             sys_clk,   // 50 MHz clock
    input  wire logic             rst,       // Async reset, high
    input  wire logic             wb_cyc_i,  // Bus cycle
    input  wire logic             wb_stb_i,  // Strobe
    input  wire logic             wb_we_i,   // Write enable
    input  wire logic [13:0]      wb_adr_i,  // Byte address
    input  wire logic [3:0]       wb_sel_i,  // Byte lanes
    input  wire logic [31:0]      wb_dat_i,  // Write data
    output logic      [31:0]      wb_dat_o,  // Read data
    output logic                  wb_ack_o,  // Acknowledge
    input  wire logic [14:0]      mseValue,  // Measured error
    output pct_pkg::pct_line_s    lineOut,   // Pair symbol
    output logic                  convergedFlag, // Below limit
    output logic                  retrainPulse,  // Gain retrain
    output pct_pkg::pct_dsp_s     dspCfg     // Tuning fields
);
    import pct_pkg::*;

    localparam int RT_W = $clog2(RETRAIN_BASE) + 8; // Timer width
    localparam int FP_W = $clog2(FRAME_LEN);        // Position width
    localparam int TK_W = $clog2(TICK_DIV + 1);     // Divider width

    // Elaboration checks
    if (TICK_DIV < 1 || FRAME_LEN < 2 || RETRAIN_BASE < 2) begin : g_bad
        $error("pct_compliance_dsp: parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Register storage
    logic [15:0] compt_reg;   // Compliance select
    logic [15:0] dsp_reg;     // Energy/watchdog control
    logic [15:0] enwin_reg;   // Energy window
    logic [15:0] mse_reg;     // Convergence limit
    logic [15:0] gain_reg;    // Gain retrain control
    logic [15:0] ext_reg;     // Extended test control

    // Bus decode
    wire [11:0] regIdx   = wb_adr_i[13:2];
    wire        busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wrStrobe = busReq && wb_we_i;
    wire        hitCompt = regIdx == `PCT_IDX_COMPT;
    wire        hitDsp   = regIdx == `PCT_IDX_DSP;
    wire        hitEnwin = regIdx == `PCT_IDX_ENWIN;
    wire        hitMse   = regIdx == `PCT_IDX_MSE;
    wire        hitGain  = regIdx == `PCT_IDX_GAIN;
    wire        hitExt   = regIdx == `PCT_IDX_EXT;
    wire [15:0] laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Unmapped addresses read as zero and still get an ack
    wire [15:0] readMux =
        hitCompt ? compt_reg :
        hitDsp   ? dsp_reg   :
        hitEnwin ? enwin_reg :
        hitMse   ? mse_reg   :
        hitGain  ? gain_reg  :
        hitExt   ? ext_reg   : 16'h0000;

    // Byte-lane and writable-bit merge of a write
    function automatic logic [15:0] wrMerge(input logic [15:0] old,
                                            input logic [15:0] wmask,
                                            input logic [15:0] lanes,
                                            input logic [15:0] wdat);
        logic [15:0] m;
        m = wmask & lanes;
        return (old & ~m) | (wdat & m);
    endfunction

    // Bus answer: ack registered one cycle after the request, drops the next cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? {16'h0000, readMux} : wb_dat_o;
        end
    end

    // Register writes; reserved bits stay zero via the masks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compt_reg <= `PCT_RST_COMPT;
            dsp_reg   <= `PCT_RST_DSP;
            enwin_reg <= `PCT_RST_ENWIN;
            mse_reg   <= `PCT_RST_MSE;
            gain_reg  <= `PCT_RST_GAIN;
            ext_reg   <= `PCT_RST_EXT;
        end else if (wrStrobe) begin
            if (hitCompt) compt_reg <= wrMerge(compt_reg, `PCT_WM_COMPT, laneMask, wb_dat_i[15:0]);
            if (hitDsp)   dsp_reg   <= wrMerge(dsp_reg, `PCT_WM_DSP, laneMask, wb_dat_i[15:0]);
            if (hitEnwin) enwin_reg <= wrMerge(enwin_reg, `PCT_WM_ENWIN, laneMask, wb_dat_i[15:0]);
            if (hitMse)   mse_reg   <= wrMerge(mse_reg, `PCT_WM_MSE, laneMask, wb_dat_i[15:0]);
            if (hitGain)  gain_reg  <= wrMerge(gain_reg, `PCT_WM_GAIN, laneMask, wb_dat_i[15:0]);
            if (hitExt)   ext_reg   <= wrMerge(ext_reg, `PCT_WM_EXT, laneMask, wb_dat_i[15:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // DSP tuning fields, wired straight from register flops
    // step select bit
    assign dspCfg = '{
        energyLostTh:   dsp_reg[15:8],
        dfeFreeze:      dsp_reg[7],
        watchdogOff:    dsp_reg[`PCT_WD_OFF],
        badMseTime:     dsp_reg[3:1],
        edgeOnlyInt:    dsp_reg[0],
        energyWindow:   enwin_reg[15:8],
        energyOnTh:     enwin_reg[7:0],
        gainStep:       gain_reg[`PCT_STEP_BIT],
        energyLostTrig: gain_reg[`PCT_ELT_BIT],
        energyLostClr:  gain_reg[`PCT_ELC_BIT],
        sequencerWatchdogCount: gain_reg[`PCT_WD_HI:0]
    };

    wire mseBelow = mseValue < mse_reg[`PCT_MSE_HI:0];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) convergedFlag <= 1'b0;
        else     convergedFlag <= mseBelow;
    end

    logic [RT_W-1:0] retrainCnt_reg;  // Clocks since last retrain
    wire  [2:0]      retrainSel = gain_reg[`PCT_RT_HI:`PCT_RT_LO];
    wire  [RT_W-1:0] retrainTop = RT_W'(RETRAIN_BASE - 1) << retrainSel
                                  | RT_W'((1 << retrainSel) - 1);
    wire             retrainHit = retrainCnt_reg >= retrainTop;
    // Interval shortened by a rewrite takes effect at once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            retrainCnt_reg <= '0;
            retrainPulse   <= 1'b0;
        end else if (!gain_reg[`PCT_GAIN_EN]) begin
            retrainCnt_reg <= '0;
            retrainPulse   <= 1'b0;
        end else begin
            retrainCnt_reg <= retrainHit ? '0 : retrainCnt_reg + 1'b1;
            retrainPulse   <= retrainHit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Symbol rate divider
    logic [TK_W-1:0] tickCnt_reg;  // Divider count
    wire symTick = tickCnt_reg == '0;
    // Width named once so the reload cast stays a plain size cast
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) tickCnt_reg <= '0;
        else     tickCnt_reg <= symTick ? TK_W'(TICK_DIV - 1)
                                        : tickCnt_reg - 1'b1;
    end

    // Mode selection; 100 Mbps test wins when both are set
    // 10 Mbps enable
    wire en10  = compt_reg[`PCT_EN_BIT];
    wire en100 = ext_reg[`PCT_EN_BIT];
    pct_mode_e modeState_reg, modeState_next;
    assign modeState_next = en100 ? PCT_T100 : en10 ? PCT_T10 : PCT_IDLE;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) modeState_reg <= PCT_IDLE;
        else     modeState_reg <= modeState_next;
    end

    wire [4:0] code100 = {ext_reg[`PCT_CODE_MSB], compt_reg[3:0]};
    logic       en100Prev_reg;  // Enable seen last cycle
    logic [4:0] loaded_reg;     // Code latched at enable rise
    logic [4:0] zeroCnt_reg;    // Position in one-then-zeros
    // code captured only on enable rise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            en100Prev_reg <= 1'b0;
            loaded_reg    <= 5'h00;
        end else begin
            en100Prev_reg <= en100;
            if (en100 && !en100Prev_reg) loaded_reg <= code100;
        end
    end

    // Frame position, random source and 100M zero counter
    logic [FP_W-1:0] framePos_reg;  // Symbol within frame
    logic [15:0]     lfsr_reg;      // Random data source
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            framePos_reg <= '0;
            lfsr_reg     <= `PCT_LFSR_SEED;
            zeroCnt_reg  <= 5'h00;
        end else if (modeState_reg == PCT_IDLE) begin
            framePos_reg <= '0;
            zeroCnt_reg  <= 5'h00;
        end else if (symTick) begin
            framePos_reg <= (framePos_reg == FP_W'(FRAME_LEN - 1)) ? '0
                            : framePos_reg + 1'b1;
            lfsr_reg     <= {1'b0, lfsr_reg[15:1]}
                            ^ (lfsr_reg[0] ? `PCT_LFSR_TAPS : 16'h0000);
            zeroCnt_reg  <= (zeroCnt_reg >= loaded_reg) ? 5'h00
                            : zeroCnt_reg + 1'b1;
        end
    end

    // Next symbol on the pair
    wire       firstSym = framePos_reg == '0;
    wire [3:0] sel10    = compt_reg[3:0];
    pct_line_s lineOut_next;
    always_comb begin
        lineOut_next = '{data: 1'b0, drive: 1'b0, idle: 1'b0};
        unique case (modeState_reg)
            PCT_IDLE: lineOut_next = '{data: 1'b0, drive: 1'b0, idle: 1'b0};
            PCT_T100: begin
                lineOut_next.drive = 1'b1;
                lineOut_next.data  = (loaded_reg != 5'h00) && (zeroCnt_reg == 5'h00);
            end
            PCT_T10: begin
                unique case (sel10)
                    4'h0: lineOut_next = '{data: firstSym, drive: firstSym, idle: 1'b0};
                    4'h1: lineOut_next = '{data: firstSym, drive: firstSym, idle: 1'b0};
                    4'h2: lineOut_next = '{data: 1'b0, drive: firstSym, idle: 1'b0};
                    4'h3: lineOut_next = '{data: 1'b1, drive: 1'b1, idle: 1'b0};
                    4'h4: lineOut_next = '{data: 1'b0, drive: 1'b1, idle: 1'b0};
                    4'h5: lineOut_next = '{data: !framePos_reg[0], drive: 1'b1, idle: 1'b0};
                    4'h6: lineOut_next = '{data: firstSym, drive: 1'b1, idle: !firstSym};
                    4'h7: lineOut_next = '{data: 1'b0, drive: 1'b1, idle: !firstSym};
                    4'h8: lineOut_next = '{data: framePos_reg[1] ~^ framePos_reg[0],
                                           drive: 1'b1, idle: 1'b0};
                    4'h9: lineOut_next = '{data: lfsr_reg[0], drive: 1'b1, idle: 1'b0};
                    4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF:
                        lineOut_next = '{data: framePos_reg[0] ^ sel10[0],
                                         drive: 1'b1, idle: 1'b1};
                endcase
            end
            default: lineOut_next = '{data: 1'b0, drive: 1'b0, idle: 1'b0};
        endcase
    end

    // Line output register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) lineOut <= '{data: 1'b0, drive: 1'b0, idle: 1'b0};
        else     lineOut <= lineOut_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
        s_req |=> s_ack_once)
        else $error("bus request not answered in one cycle");

    a_conv_compare: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 convergedFlag == $past(mseValue < mse_reg[`PCT_MSE_HI:0]))
        else $error("convergence flag wrong");

    a_code_load: assert property (@(posedge sys_clk) disable iff (rst)
        (en100 && !en100Prev_reg) |=> loaded_reg == $past(code100))
        else $error("test code not captured at enable rise");

    a_code_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (en100 && en100Prev_reg) |=> $stable(loaded_reg))
        else $error("test code changed while enabled");

    a_mode_follow: assert property (@(posedge sys_clk) disable iff (rst)
        en100 |=> modeState_reg == PCT_T100)
        else $error("100M test mode not entered");

    a_one_first: assert property (@(posedge sys_clk) disable iff (rst)
        (modeState_reg == PCT_T100 && loaded_reg != 5'h00 && zeroCnt_reg == 5'h00)
        |=> lineOut.data && lineOut.drive)
        else $error("leading one missing");

    a_cleared_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (modeState_reg == PCT_T100 && loaded_reg == 5'h00) |=> !lineOut.data)
        else $error("cleared pattern not zero");

    a_rep_ones: assert property (@(posedge sys_clk) disable iff (rst)
        (modeState_reg == PCT_T10 && sel10 == 4'h3) |=> lineOut.data && lineOut.drive)
        else $error("repeated ones broken");

    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        (!en10 && !en100) [*2] |=> !lineOut.drive)
        else $error("pair driven after disable");
endmodule

// ### tb/pct_line_tester.sv
// Test equipment model on the transmit pair: counts driven, one and idle clocks, feeds error level
// Assumes the bench reads its counters in the active region after a clock edge
`timescale 1ns/10ps
module pct_line_tester (
    input  wire logic               sys_clk,  // Bench clock
    input  wire pct_pkg::pct_line_s lineOut,  // Symbol on the pair
    output logic [14:0]             mseValue  // Error seen by receiver
);
    import pct_pkg::*;
    int unsigned onesCnt  = 0;  // Clocks with a driven one
    int unsigned driveCnt = 0;  // Clocks with the pair driven
    int unsigned idleCnt  = 0;  // Clocks in idle waveform
    initial mseValue = 15'h7FFF;  // Poor error until told otherwise
    ////////////////////////////////////////////////////////////////////
    // Free-running tallies; the bench works on differences only
    always @(posedge sys_clk) begin
        onesCnt  <= onesCnt + 32'(lineOut.drive & lineOut.data);
        driveCnt <= driveCnt + 32'(lineOut.drive);
        idleCnt  <= idleCnt + 32'(lineOut.idle);
    end
    // Error level changes only just after an edge
    task automatic set_mse(input logic [14:0] v);
        mseValue <= v;
    endtask
endmodule

// ### tb/pct_compliance_dsp_test.sv
// Self-checking bench for the compliance pattern and DSP tuning block
// Assumes pct_regs.svh constants and shortened count parameters below
`timescale 1ns/10ps
`include "pct_regs.svh"
module pct_compliance_dsp_test;
    import pct_pkg::*;
    localparam int TICK = 5;   // Clocks per symbol
    localparam int FLEN = 4;   // Shortened frame
    localparam int RBASE = 16; // Shortened retrain base
    logic sys_clk = 1'b0, rst = 1'b1;  // Clock and reset
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;  // Bus controls
    logic [13:0] wbAdr = 14'h0000;  // Byte address
    logic [3:0]  wbSel = 4'h0;      // Byte lanes
    logic [31:0] wbDatI = 32'h0, wbDatO;  // Bus data
    logic        wbAck, convergedFlag, retrainPulse;  // Outputs
    logic [14:0] mseValue;  // From tester
    pct_line_s   lineOut;   // Pair symbol
    pct_dsp_s    dspCfg;    // Tuning fields
    int errorCnt = 0, nCompared = 0, retrainCnt = 0;  // Tallies
    int unsigned o, d, i;  // Measured counts
    logic [31:0] r;        // Read scratch, whole word
    pct_compliance_dsp #(.TICK_DIV(TICK), .FRAME_LEN(FLEN), .RETRAIN_BASE(RBASE)) DUT (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .mseValue(mseValue), .lineOut(lineOut),
        .convergedFlag(convergedFlag), .retrainPulse(retrainPulse), .dspCfg(dspCfg));
    pct_line_tester tester (.sys_clk(sys_clk), .lineOut(lineOut), .mseValue(mseValue));
    initial forever #10 sys_clk = ~sys_clk;  // 50 MHz
    always @(posedge sys_clk) retrainCnt <= retrainCnt + int'(retrainPulse);
    ////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Compared %0d, errors %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One classic cycle; held until ack is sampled, then released
    task automatic xfer(input logic w, input logic [11:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        {wbCyc, wbStb, wbWe, wbSel} <= {1'b1, 1'b1, w, 4'h3};
        wbAdr <= {idx, 2'b00};
        wbDatI <= {16'h0000, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        r = wbDatO;
        {wbCyc, wbStb, wbWe} <= 3'b000;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [15:0] v);
        xfer(1'b1, idx, v);
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [15:0] exp);
        xfer(1'b0, idx, 16'h0000);
        chk(r, {16'h0, exp});
    endtask
    // Settle, then tally the pair over a whole number of periods
    task automatic meas(input int clks);
        int unsigned o0, d0, i0;
        repeat (10) @(posedge sys_clk);
        {o0, d0, i0} = {tester.onesCnt, tester.driveCnt, tester.idleCnt};
        repeat (clks) @(posedge sys_clk);
        {o, d, i} = {tester.onesCnt - o0, tester.driveCnt - d0, tester.idleCnt - i0};
    endtask
    ////////////////////////////////////////////////////////////////////
    // Tables: register index, reset value, writable mask, pattern tallies
    logic [11:0] ix [6] = '{`PCT_IDX_COMPT, `PCT_IDX_DSP, `PCT_IDX_ENWIN,
                            `PCT_IDX_MSE, `PCT_IDX_GAIN, `PCT_IDX_EXT};
    logic [15:0] rv [6] = '{16'h0000, 16'h2082, 16'h2040, 16'h051C, 16'h4F28, 16'h0000};
    logic [15:0] wm [6] = '{16'h001F, 16'hFF9F, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'h0030};
    int onesX [10] = '{50, 50, 0, 200, 0, 100, 50, 0, 100, -1};  // -1: not judged
    int drvX  [10] = '{50, 50, 50, 200, 200, 200, 200, 200, 200, 200};
    int c100  [4]  = '{1, 3, 16, 31};  // 100M codes incl. top bit
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) rdc(ix[k], rv[k]);
        chk(32'({dspCfg.gainStep, dspCfg.energyLostTrig, dspCfg.energyLostClr}), 32'h7);
        chk(32'(dspCfg.sequencerWatchdogCount), 32'h28);
        chk(32'({dspCfg.energyLostTh, dspCfg.energyWindow, dspCfg.energyOnTh}), 32'h202040);
        for (int k = 0; k < 6; k++) begin
            wr(ix[k], 16'hFFFF);
            rdc(ix[k], wm[k]);
            wr(ix[k], rv[k]);
        end
        // Basic mode control is not in this block: ignored, reads zero
        wr(12'h000, 16'h2100);
        rdc(12'h000, 16'h0000);
        // 10M patterns, every code, frame of FLEN symbols
        for (int c = 0; c < 16; c++) begin
            wr(`PCT_IDX_COMPT, 16'h0010 | 16'(c));
            meas(TICK * FLEN * 10);
            if (c > 9) chk(i, 200);
            else if (onesX[c] >= 0) chk(o, onesX[c]);
            if (c < 10 && drvX[c] >= 0) chk(d, drvX[c]);
        end
        wr(`PCT_IDX_COMPT, 16'h0003);
        meas(100);
        chk(d, 0);
        // 100M codes; 10M enable also set to see 100M win
        foreach (c100[k]) begin
            wr(`PCT_IDX_EXT, 16'h0000);
            wr(`PCT_IDX_COMPT, 16'h0010 | 16'(c100[k] & 15));
            wr(`PCT_IDX_EXT, 16'h0010 | 16'((c100[k] >> 4) << 5));
            meas((c100[k] + 1) * TICK * 4);
            chk(o, 4 * TICK);
            chk(d, (c100[k] + 1) * TICK * 4);
        end
        // Code change without the bit 4 toggle is held off
        // Code 31 still latched: two whole periods give two leading ones
        wr(`PCT_IDX_COMPT, 16'h0013);
        meas(64 * TICK);
        chk(o, 2 * TICK);
        wr(`PCT_IDX_EXT, 16'h0000);
        wr(`PCT_IDX_EXT, 16'h0010);
        meas(80);
        chk(o, 20);
        wr(`PCT_IDX_EXT, 16'h0000);
        wr(`PCT_IDX_COMPT, 16'h0010);
        wr(`PCT_IDX_EXT, 16'h0010);
        meas(200);
        chk(o, 0);
        wr(`PCT_IDX_EXT, 16'h0000);
        // Convergence against reset limit at both boundaries, written limit just below only
        tester.set_mse(15'h051B);
        repeat (3) @(posedge sys_clk);
        chk(32'(convergedFlag), 32'h1);
        tester.set_mse(15'h051C);
        repeat (3) @(posedge sys_clk);
        chk(32'(convergedFlag), 32'h0);
        wr(`PCT_IDX_MSE, 16'h0010);
        tester.set_mse(15'h000F);
        repeat (3) @(posedge sys_clk);
        chk(32'(convergedFlag), 32'h1);
        // Retrain period is RBASE shifted by the interval field
        // Enable bit low: timer cleared to zero, no pulses at all
        wr(`PCT_IDX_GAIN, 16'h4728);
        meas(0);
        o = retrainCnt;
        repeat (RBASE << 6) @(posedge sys_clk);
        chk(retrainCnt - o, 0);
        wr(`PCT_IDX_GAIN, 16'h4F28);
        meas(0);
        o = retrainCnt;
        repeat (RBASE << 6) @(posedge sys_clk);
        chk(retrainCnt - o, 4);
        wr(`PCT_IDX_GAIN, 16'h0F28);
        meas(0);
        o = retrainCnt;
        repeat (RBASE * 10) @(posedge sys_clk);
        chk(retrainCnt - o, 10);
        wr(`PCT_IDX_GAIN, 16'h0028);
        chk(32'({dspCfg.gainStep, dspCfg.energyLostTrig, dspCfg.energyLostClr}), 32'h0);
        print_verdict();
    end
    // Hang guard, well past the expected run
    initial begin
        #1000000;
        errorCnt++;
        print_verdict();
    end
endmodule
